/* File: design/hall_commutation_decoder.sv */
`timescale 1ns/1ps
module hall_commutation_decoder (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Rotor position sensors
  input wire logic hall_input_first,
  input wire logic hall_input_second,
  input wire logic hall_input_third,
  // Control pins
  input wire logic direction_fwd,
  input wire logic run_enable,
  input wire logic phasing_sel_60,
  input wire logic four_step_mode,
  // Top drives, active low
  output logic top_drive_phase_one_n,
  output logic top_drive_phase_two_n,
  output logic top_drive_phase_three_n,
  // Bottom drives, active high
  output logic bottom_drive_phase_one,
  output logic bottom_drive_phase_two,
  output logic bottom_drive_phase_three
);
  import hall_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  pins_t pins_raw;
  pins_t pins_s;
  logic [PIN_WIDTH-1:0] pins_s_vec;

  assign pins_raw = '{four_step: four_step_mode, sel_60: phasing_sel_60,
                      enable: run_enable, fwd: direction_fwd,
                      hall: {hall_input_first, hall_input_second, hall_input_third}};
  assign pins_s = pins_t'(pins_s_vec);

  pin_sync #(.WIDTH(PIN_WIDTH), .RESET_VALUE(PINS_RESET)) u_pin_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(pins_raw),
    .dout(pins_s_vec)
  );

  // ------------------------------------------------------------
  // Step lookup, result is {valid, step}
  // ------------------------------------------------------------
  // Each valid code is one of six steps; the two unused codes give no drive
  function automatic logic [3:0] step_120(input logic [2:0] c);
    case (c)
      3'h5: step_120 = 4'h8;
      3'h4: step_120 = 4'h9;
      3'h6: step_120 = 4'ha;
      3'h2: step_120 = 4'hb;
      3'h3: step_120 = 4'hc;
      3'h1: step_120 = 4'hd;
      default: step_120 = 4'h0;
    endcase
  endfunction : step_120

  function automatic logic [3:0] step_60(input logic [2:0] c);
    case (c)
      3'h4: step_60 = 4'h8;
      3'h6: step_60 = 4'h9;
      3'h7: step_60 = 4'ha;
      3'h3: step_60 = 4'hb;
      3'h1: step_60 = 4'hc;
      3'h0: step_60 = 4'hd;
      default: step_60 = 4'h0;
    endcase
  endfunction : step_60

  // One top and one bottom of different phases per step; reverse swaps them
  function automatic drive_t six_step(input logic [3:0] vs, input logic fwd);
    drive_t d;
    logic [1:0] t;
    logic [1:0] b;
    d = DRIVE_OFF;
    t = 2'd0;
    b = 2'd1;
    case (vs[2:0])
      3'd0: begin t = 2'd0; b = 2'd1; end
      3'd1: begin t = 2'd0; b = 2'd2; end
      3'd2: begin t = 2'd1; b = 2'd2; end
      3'd3: begin t = 2'd1; b = 2'd0; end
      3'd4: begin t = 2'd2; b = 2'd0; end
      3'd5: begin t = 2'd2; b = 2'd1; end
      default: begin t = 2'd0; b = 2'd1; end
    endcase
    // Swapping top and bottom reverses each step's current, so the motor turns the other way
    if (!fwd) begin
      {t, b} = {b, t};
    end
    if (vs[3]) begin
      d.top_n[t] = 1'b0;
      d.bottom[b] = 1'b1;
    end
    return d;
  endfunction : six_step

  // Four states from the first two sensors; phase one held off
  function automatic drive_t four_step(input logic [1:0] ab, input logic fwd);
    drive_t d;
    logic [3:0] v;
    case ({fwd, ab})
      3'h6: v = FS_FWD_10;
      3'h7: v = FS_FWD_11;
      3'h5: v = FS_FWD_01;
      3'h4: v = FS_FWD_00;
      3'h2: v = FS_REV_10;
      3'h3: v = FS_REV_11;
      3'h1: v = FS_REV_01;
      default: v = FS_REV_00;
    endcase
    d.top_n = {v[2], v[3], 1'b1};
    d.bottom = {v[0], v[1], 1'b0};
    return d;
  endfunction : four_step

  // ------------------------------------------------------------
  // Decode and enable gating
  // ------------------------------------------------------------
  wire [3:0] step_sel = pins_s.sel_60 ? step_60(pins_s.hall) : step_120(pins_s.hall);
  drive_t drive_six;
  drive_t drive_four;
  drive_t drive_mux;
  drive_t next_drive;
  drive_t drive;

  assign drive_six = six_step(step_sel, pins_s.fwd);
  assign drive_four = four_step(pins_s.hall[2:1], pins_s.fwd);
  // Joined second and third sensors collapse the table to four states
  assign drive_mux = pins_s.four_step ? drive_four : drive_six;
  // Gating only the tops lets the bottoms still brake with enable low
  assign next_drive = '{top_n: drive_mux.top_n | {3{~pins_s.enable}},
                        bottom: drive_mux.bottom};

  // Output register: glitch-free drives, no commutation history kept
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      drive <= DRIVE_OFF;
    end else begin
      drive <= next_drive;
    end
  end

  assign top_drive_phase_one_n = drive.top_n[0];
  assign top_drive_phase_two_n = drive.top_n[1];
  assign top_drive_phase_three_n = drive.top_n[2];
  assign bottom_drive_phase_one = drive.bottom[0];
  assign bottom_drive_phase_two = drive.bottom[1];
  assign bottom_drive_phase_three = drive.bottom[2];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_enable_low;
    @(posedge clk_sys) disable iff (!rstn)
    !pins_s.enable |=> drive.top_n == TOP_OFF;
  endproperty
  a_enable_low: assert property (p_enable_low) else $error("top drive on while disabled");

  property p_four_unused;
    @(posedge clk_sys) disable iff (!rstn)
    pins_s.four_step |=> drive.top_n[0] && !drive.bottom[0];
  endproperty
  a_four_unused: assert property (p_four_unused) else $error("phase one used in four step");

  property p_four_fwd;
    @(posedge clk_sys) disable iff (!rstn)
    pins_s.four_step && pins_s.fwd && pins_s.enable && pins_s.hall[2:1] == 2'h1
      |=> drive.top_n == 3'h3 && drive.bottom == 3'h0;
  endproperty
  a_four_fwd: assert property (p_four_fwd) else $error("four step forward code 01 wrong");

  property p_four_rev;
    @(posedge clk_sys) disable iff (!rstn)
    pins_s.four_step && !pins_s.fwd && pins_s.enable && pins_s.hall[2:1] == 2'h3
      |=> drive.top_n == 3'h7 && drive.bottom == 3'h2;
  endproperty
  a_four_rev: assert property (p_four_rev) else $error("four step reverse code 11 wrong");

  property p_four_states;
    @(posedge clk_sys) disable iff (!rstn)
    pins_s.four_step |=> drive.bottom == 3'h0 || drive.bottom == 3'h2 || drive.bottom == 3'h4;
  endproperty
  a_four_states: assert property (p_four_states) else $error("four step bottom state illegal");

  property p_sixty_pair;
    @(posedge clk_sys) disable iff (!rstn)
    !pins_s.four_step && pins_s.sel_60 && pins_s.enable && pins_s.hall == 3'h7
      |=> ($past(pins_s.fwd) ? drive.bottom == 3'h4 : drive.bottom == 3'h2)
          && $countones(~drive.top_n) == 1
          && $countones(drive.bottom) == 1 && (~drive.top_n & drive.bottom) == 3'h0;
  endproperty
  a_sixty_pair: assert property (p_sixty_pair) else $error("60 degree step lacks one top/bottom");

  property p_sixty_reverse;
    @(posedge clk_sys) disable iff (!rstn)
    !pins_s.four_step && pins_s.sel_60 && pins_s.enable && !pins_s.fwd && pins_s.hall == 3'h4
      |=> drive.top_n == 3'h5 && drive.bottom == 3'h1;
  endproperty
  a_sixty_reverse: assert property (p_sixty_reverse) else $error("60 degree reverse wrong");

  property p_one_twenty;
    @(posedge clk_sys) disable iff (!rstn)
    !pins_s.four_step && !pins_s.sel_60 && pins_s.hall == 3'h7
      |=> drive.top_n == TOP_OFF && drive.bottom == BOTTOM_OFF;
  endproperty
  a_one_twenty: assert property (p_one_twenty) else $error("120 degree bad code drives");

  property p_one_twenty_fwd;
    @(posedge clk_sys) disable iff (!rstn)
    !pins_s.four_step && !pins_s.sel_60 && pins_s.enable && pins_s.fwd && pins_s.hall == 3'h6
      |=> drive.top_n == 3'h5 && drive.bottom == 3'h4;
  endproperty
  a_one_twenty_fwd: assert property (p_one_twenty_fwd) else $error("120 degree step wrong");

  property p_stateless;
    @(posedge clk_sys) disable iff (!rstn)
    $stable(pins_s) ##1 $stable(pins_s) |=> $stable(drive);
  endproperty
  a_stateless: assert property (p_stateless) else $error("drive moved with steady inputs");

  c_four_step: cover property (@(posedge clk_sys) disable iff (!rstn)
    pins_s.four_step && pins_s.enable ##1 drive.bottom == 3'h4);
  c_sixty_run: cover property (@(posedge clk_sys) disable iff (!rstn)
    pins_s.sel_60 && pins_s.hall == 3'h4 ##1 pins_s.hall == 3'h6);
  c_disable: cover property (@(posedge clk_sys) disable iff (!rstn)
    pins_s.enable ##1 !pins_s.enable);

endmodule : hall_commutation_decoder

/* File: design/hall_pkg.sv */
package hall_pkg;

  // ------------------------------------------------------------
  // Pin and drive carriers
  // ------------------------------------------------------------
  // Sensor code order: hall[2] = first, hall[1] = second, hall[0] = third
  typedef struct packed {
    logic four_step;
    logic sel_60;
    logic enable;
    logic fwd;
    logic [2:0] hall;
  } pins_t;

  // Index 0 = phase one, 1 = phase two, 2 = phase three; tops active low
  typedef struct packed {
    logic [2:0] top_n;
    logic [2:0] bottom;
  } drive_t;

  localparam int PIN_WIDTH = $bits(pins_t);
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // Reset and idle values
  // ------------------------------------------------------------
  localparam logic [2:0] TOP_OFF = 3'h7;
  localparam logic [2:0] BOTTOM_OFF = 3'h0;
  localparam drive_t DRIVE_OFF = '{top_n: TOP_OFF, bottom: BOTTOM_OFF};
  localparam logic [PIN_WIDTH-1:0] PINS_RESET = 7'h00;

  // ------------------------------------------------------------
  // Four step table, value packed as {top2, top3, bottom2, bottom3}
  // ------------------------------------------------------------
  localparam logic [3:0] FS_FWD_10 = 4'hd;
  localparam logic [3:0] FS_FWD_11 = 4'h4;
  localparam logic [3:0] FS_FWD_01 = 4'h8;
  localparam logic [3:0] FS_FWD_00 = 4'he;
  localparam logic [3:0] FS_REV_10 = 4'h8;
  localparam logic [3:0] FS_REV_11 = 4'he;
  localparam logic [3:0] FS_REV_01 = 4'hd;
  localparam logic [3:0] FS_REV_00 = 4'h4;

endpackage : hall_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // Two flops; only the second flop reads the first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stage1 <= RESET_VALUE;
      dout <= RESET_VALUE;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule : pin_sync

/* File: tb/hall_sensor_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Rotor position sensors
// ------------------------------------------------------------
module hall_sensor_model (
  // Motor set-up: 0 = 60, 1 = 120, 2 = 240, 3 = 300 degree
  input wire logic [1:0] conv,
  input wire logic [2:0] step,
  input wire logic four_step,
  // Deliberate bad code, only when a scenario asks
  input wire logic inject,
  input wire logic [2:0] inj_code,
  // Sensor lines A, B, C
  output logic [2:0] hall
);
  // One code per 60 degree step, six per revolution
  localparam logic [2:0] SEQ [4][6] = '{'{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0},
                                        '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1},
                                        '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2},
                                        '{3'h7, 3'h6, 3'h4, 3'h0, 3'h1, 3'h3}};
  // Two sensors 90 degrees apart give a quadrature code
  localparam logic [1:0] QUAD [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  logic [1:0] ab;
  assign ab = QUAD[step[1:0]];
  // Second and third lines joined in four step use
  assign hall = inject ? inj_code : four_step ? {ab, ab[0]} : SEQ[conv][step];
endmodule : hall_sensor_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import hall_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  logic clk_sys, rstn, direction_fwd, run_enable, four, inject;
  logic [1:0] conv;
  logic [2:0] step, inj_code, hall;
  logic [5:0] obs;
  logic phasing_sel_60;
  int n_errors = 0;
  int checked = 0;
  logic [5:0] exp_q[$];
  event result_ev;
  localparam logic [2:0] C60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  localparam logic [2:0] C120 [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  localparam int TP [6] = '{0, 0, 1, 1, 2, 2};
  localparam int BP [6] = '{1, 2, 2, 0, 0, 1};
  // 60 and 300 motors use the 60 setting
  assign phasing_sel_60 = (conv == 2'h0) || (conv == 2'h3);
  hall_sensor_model sensors (.conv(conv), .step(step), .four_step(four), .inject(inject),
    .inj_code(inj_code), .hall(hall));
  hall_commutation_decoder uut (.clk_sys(clk_sys), .rstn(rstn),
    .hall_input_first(hall[2]), .hall_input_second(hall[1]), .hall_input_third(hall[0]),
    .direction_fwd(direction_fwd), .run_enable(run_enable),
    .phasing_sel_60(phasing_sel_60), .four_step_mode(four),
    .top_drive_phase_one_n(obs[3]), .top_drive_phase_two_n(obs[4]),
    .top_drive_phase_three_n(obs[5]), .bottom_drive_phase_one(obs[0]),
    .bottom_drive_phase_two(obs[1]), .bottom_drive_phase_three(obs[2]));
  // Drive word {top3_n, top2_n, top1_n, bot3, bot2, bot1}; unknown codes drive nothing
  function automatic logic [5:0] exp_drive(logic [2:0] h, logic s60, fw, en, fs);
    logic [5:0] r;
    logic [3:0] f;
    r = 6'h38;
    if (fs) begin
      case ({h[2:1], fw})
        3'h5: f = 4'hd;
        3'h7: f = 4'h4;
        3'h3: f = 4'h8;
        3'h1: f = 4'he;
        3'h4: f = 4'h8;
        3'h6: f = 4'he;
        3'h2: f = 4'hd;
        default: f = 4'h4;
      endcase
      r = {f[2], f[3], 1'b1, f[0], f[1], 1'b0};
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (h === (s60 ? C60[k] : C120[k])) begin
          r = {~(3'h1 << (fw ? TP[k] : BP[k])), 3'h1 << (fw ? BP[k] : TP[k])};
        end
      end
    end
    if (!en) r[5:3] = 3'h7;
    return r;
  endfunction : exp_drive
  task automatic check(input logic [5:0] seen, input logic [5:0] expd);
    checked++;
    if (seen !== expd) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic final_report;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Pins settle through three flops, so look four edges on
  task automatic apply(input logic [1:0] cv, input logic [2:0] st,
                       input logic fs, fw, en, inj, input logic [2:0] ic);
    @(negedge clk_sys);
    conv = cv;
    step = st;
    four = fs;
    direction_fwd = fw;
    run_enable = en;
    inject = inj;
    inj_code = ic;
    repeat (4) @(posedge clk_sys);
    #1;
    exp_q.push_back(exp_drive(hall, phasing_sel_60, fw, en, fs));
    ->result_ev;
  endtask : apply
  // ------------------------------------------------------------
  // Clock, watchdog, monitor, sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
  initial forever begin
    @(result_ev);
    check(obs, exp_q.pop_front());
  end
  initial begin
    {rstn, conv, step, four, direction_fwd, run_enable, inject, inj_code} = '0;
    void'($urandom(32'h8e4f));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'b1;
    // Every convention, both directions, enable high and low
    for (int c = 0; c < 4; c++)
      for (int d = 0; d < 4; d++)
        for (int s = 0; s < 6; s++) apply(c[1:0], s[2:0], 1'b0, d[0], d[1], 1'b0, 3'h0);
    $display("six step tables done");
    // Four step with phasing select toggling, which must not matter
    for (int d = 0; d < 4; d++)
      for (int s = 0; s < 4; s++) apply({1'b0, s[0]}, s[2:0], 1'b1, d[0], d[1], 1'b0, 3'h0);
    $display("four step tables done");
    // Codes outside each setting's sequence
    apply(2'h0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h5);
    apply(2'h0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h2);
    apply(2'h1, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h7);
    apply(2'h1, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
    $display("invalid codes done");
    // Random jumps show no stored step
    repeat (60) apply(2'($urandom % 4), 3'($urandom % 6), 1'($urandom % 2),
                      1'($urandom % 2), 1'($urandom % 2), 1'b0, 3'h0);
    $display("random jumps done");
    repeat (2) @(posedge clk_sys);
    final_report();
  end
endmodule : testbench
